// ---- dv/pcmb_far_end.sv ----
// Purpose: far party model driving bit clock, sync and receive data
// Assumes: 160 ns bit clock, still and low between frames
// Notes:   counts enable slips at each sampling point
`default_nettype none

module pcmb_far_end (
	// control
	input  wire logic       i_go,
	input  wire logic       i_gci,
	input  wire logic       i_b2,
	input  wire logic       i_hi,
	input  wire logic [7:0] i_word,
	// link pins
	output var  logic       o_clk,
	output var  logic       o_sync,
	output var  logic       o_data,
	input  wire logic       i_line,
	input  wire logic       i_oe,
	// results
	output var  logic [7:0] o_got,
	output var  logic [7:0] o_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	int   n;
	int   s;
	logic in_slot;

	initial begin
		o_clk = 1'h0;
		o_sync = 1'h0;
		o_data = 1'h0;
		o_got = 8'h00;
		o_bad = 8'h00;
		forever begin
			@(posedge i_go);
			// pins move by nba on clock edges: no race with the sampler
			n = i_b2 ? 16 : 8;
			s = i_b2 ? 8 : 0;
			if (!i_gci) begin
				o_sync <= 1'h1;
				#40 o_clk <= 1'h1;
				#40 o_clk <= 1'h0;
				#40 o_sync <= 1'h0;
				#40;
			end else if (i_hi) begin
				o_clk <= 1'h1;
				#40 o_sync <= 1'h1;
			end else begin
				o_sync <= 1'h1;
				#40 o_clk <= 1'h1;
			end
			for (int k = 0; k < n; k++) begin
				in_slot = k >= s && k < s + 8;
				if (!i_gci || k > 0)
					o_clk <= 1'h1;
				// released data line toggles, never holds
				o_data <= in_slot ? i_word[7 - (k - s)] : ~o_data;
				#80 o_clk <= 1'h0;
				if (i_gci) begin
					#80 o_clk <= 1'h1;
					o_sync <= 1'h0;
				end
				if (i_oe !== in_slot)
					o_bad = o_bad + 8'h01;
				if (in_slot)
					o_got[7 - (k - s)] = i_line;
				if (i_gci)
					#80 o_clk <= 1'h0;
				#80;
			end
		end
	end
endmodule // pcmb_far_end

`default_nettype wire

// ---- dv/pcmb_port_sva.sv ----
// Purpose: port-level checks of the serial pcm port
// Assumes: pins are oversampled by i_clock
// Notes:   bit clock edges are seen raw, ahead of the synchroniser
`default_nettype none

module pcmb_chk (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_gci_mode,
	input wire logic i_b2_select,
	input wire logic o_tx_taken,
	input wire logic o_rx_valid,
	input wire logic i_link_bit_clock,
	input wire logic o_link_transmit_data,
	input wire logic o_link_transmit_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_q;
	logic [4:0] falls;
	wire        c  = i_link_bit_clock;
	wire        oe = o_link_transmit_oe;

	// falls seen while driving; a word never spans more
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			clk_q <= 1'h0;
			falls <= 5'h00;
		end else begin
			clk_q <= c;
			falls <= oe ? falls + {4'h0, clk_q & ~c} : 5'h00;
		end
	end

	sequence s_b1_go;
		o_tx_taken && !i_b2_select;
	endsequence

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_oe_on_rise: assert property ($rose(oe) |-> c)
		else $error("output enabled while bit clock low");
	a_data_on_rise: assert property ($past(oe) && oe &&
		$changed(o_link_transmit_data) |-> c && $past(c, 3))
		else $error("data changed off a rising edge");
	a_oe_off_fall: assert property ($fell(oe) |-> !c)
		else $error("output released while bit clock high");
	a_rx_after_release: assert property (
		o_rx_valid |-> !oe && $past(oe, 3))
		else $error("word delivered off the release");
	a_b1_slot_start: assert property (
		s_b1_go |-> ##[1:100] oe)
		else $error("first slot not driven in time");
	a_fall_bound: assert property (
		oe |-> falls <= (i_gci_mode ? 5'h10 : 5'h08))
		else $error("output held beyond its word");
	a_valid_pulse: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("receive valid longer than a cycle");
	a_taken_pulse: assert property (o_tx_taken |=> !o_tx_taken)
		else $error("taken pulse longer than a cycle");
endmodule // pcmb_chk

bind pcmb_port pcmb_chk pcmb_chk_inst (
	.i_clock, .i_rst, .i_gci_mode, .i_b2_select, .o_tx_taken,
	.o_rx_valid, .i_link_bit_clock, .o_link_transmit_data,
	.o_link_transmit_oe
);

`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench of the serial pcm port
// Assumes: short frames of FRAME cycles
// Notes:   each mode, slot and sync phase runs twice, random words
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FRAME = 4000;
	logic       i_clock = 1'h0, i_rst = 1'h1, hi = 1'h0, go = 1'h0;
	logic       i_gci_mode = 1'h0, i_b2_select = 1'h0;
	logic [7:0] i_tx_word = 8'h00, rxw = 8'h00;
	logic [7:0] got, bad, o_rx_word;
	logic       o_tx_taken, o_rx_valid, o_sync_late, line;
	logic       i_link_bit_clock, i_link_frame_sync, i_link_receive_data;
	logic       o_link_transmit_data, o_link_transmit_oe;
	int         err_count = 0, total_checks = 0, seed = 32'hdea0;

	always #2 i_clock = ~i_clock;
	assign line = o_link_transmit_oe ? o_link_transmit_data : 1'bz;

	pcmb_port #(.FRAME_CYCLES(FRAME)) pcmb_port_inst (
		.i_clock, .i_rst, .i_gci_mode, .i_b2_select, .i_tx_word,
		.o_tx_taken, .o_rx_word, .o_rx_valid, .o_sync_late,
		.i_link_bit_clock, .i_link_frame_sync, .i_link_receive_data,
		.o_link_transmit_data, .o_link_transmit_oe);
	pcmb_far_end pcmb_far_end_inst (.i_go(go), .i_gci(i_gci_mode),
		.i_b2(i_b2_select), .i_hi(hi), .i_word(rxw),
		.o_clk(i_link_bit_clock), .o_sync(i_link_frame_sync),
		.o_data(i_link_receive_data), .i_line(line),
		.i_oe(o_link_transmit_oe), .o_got(got), .o_bad(bad));

	task automatic check(input logic [7:0] a, input logic [7:0] e);
		total_checks++;
		if (a !== e) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic frame(input logic g, input logic b, input logic h);
		int t;
		@(posedge i_clock);
		i_gci_mode <= g;
		i_b2_select <= b;
		hi <= h;
		i_tx_word <= 8'($random(seed));
		rxw <= 8'($random(seed));
		@(posedge i_clock);
		go <= 1'h1;
		@(posedge i_clock);
		go <= 1'h0;
		t = 0;
		while (o_rx_valid !== 1'h1 && t < FRAME) begin
			@(negedge i_clock);
			t++;
		end
		if (t == FRAME) begin
			err_count++;
			print_verdict;
		end
		check(o_rx_word, rxw);
		check(got, i_tx_word);
		check(bad, 8'h00);
		repeat (FRAME - t - 8) @(posedge i_clock);
	endtask

	initial begin
		repeat (3) @(posedge i_clock);
		i_rst <= 1'h0;
		for (int i = 0; i < 16; i++)
			frame(i[0], i[1], i[2]);
		#1;
		check({7'h00, o_sync_late}, 8'h00);
		repeat (FRAME * 9 / 8 + 100) @(posedge i_clock);
		#1;
		check({7'h00, o_sync_late}, 8'h01);
		print_verdict;
	end
endmodule // testbench

`default_nettype wire

// ---- rtl/pcmb_consts.svh ----
// Purpose: constants of the serial pcm port (offsets, timing, slot layout)
// Assumes: included by bare name from rtl files
// Notes:   frame length in cycles is an overridable module parameter; the late count follows from it
`ifndef PCMB_CONSTS_SVH
`define PCMB_CONSTS_SVH

// word layout
`define PCMB_WORD_BITS   8
`define PCMB_POS_BITS    10
`define PCMB_B1_START    10'h000
`define PCMB_B2_START    8

// timing
`define PCMB_CLK_NS      4
`define PCMB_FRAME_NS    125000
`define PCMB_LATE_DIV    8

`endif

// ---- rtl/pcmb_pkg.sv ----
// Purpose: shared types of the serial pcm port
// Assumes: nothing
// Notes:   constants live in pcmb_consts.svh
`default_nettype none

package pcmb_pkg;

	// frame sequencer
	typedef enum logic {
		PCMB_ST_IDLE,
		PCMB_ST_RUN
	} pcmb_state_t;

	// bit position within a frame
	typedef logic [9:0] pcmb_pos_t;

endpackage

`default_nettype wire

// ---- rtl/pcmb_port.sv ----
// Purpose: serial pcm b-channel port, interchip-link and gci frame modes
// Assumes: bit clock, frame sync and receive data come from the far party
//          and are oversampled by i_clock (at least 8x the bit clock)
// Notes:   one transmit and one receive word per frame, same slot
//
// Operation
// - link mode: transmit and receive words share one b channel
// - gci mode: transmit and receive words share one b channel
// - link mode: frame sync sampled on a bit clock falling edge
// - link mode: receive bits captured on bit clock falling edges
// - link mode: output leaves high impedance on rising edge at slot start
// - link mode: each further bit presented on a rising edge
// - link mode: output released after the falling edge ending the word
// - gci mode: frame pulse confirmed on a bit clock falling edge
// - gci mode: first bit driven on first clock rise after sync rise
// - gci mode: sync rising while clock high drives data at once
// - gci mode: further bits updated on clock rising edges
// - gci mode: output released on second falling edge of last bit
// - gci mode: receive bits captured on a clock rising edge
`default_nettype none
`include "pcmb_consts.svh"

module pcmb_port #(
	parameter int unsigned B2_START     = `PCMB_B2_START,
	parameter int unsigned FRAME_CYCLES = `PCMB_FRAME_NS / `PCMB_CLK_NS
) (
	// system
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// configuration, same clock domain
	input  wire logic       i_gci_mode,
	input  wire logic       i_b2_select,
	// user data
	input  wire logic [7:0] i_tx_word,
	output var  logic       o_tx_taken,
	output var  logic [7:0] o_rx_word,
	output var  logic       o_rx_valid,
	output var  logic       o_sync_late,
	// link pins (carry dcl, fsc, din, dout in gci mode)
	input  wire logic       i_link_bit_clock,
	input  wire logic       i_link_frame_sync,
	input  wire logic       i_link_receive_data,
	output var  logic       o_link_transmit_data,
	output var  logic       o_link_transmit_oe
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	localparam int unsigned LATE_CYCLES =
		FRAME_CYCLES + FRAME_CYCLES / `PCMB_LATE_DIV;
	localparam int unsigned WD_BITS = $clog2(LATE_CYCLES + 1);

	function automatic logic in_slot(input pcmb_pkg::pcmb_pos_t pos,
			input pcmb_pkg::pcmb_pos_t start);
		in_slot = (pos >= start) &&
			(pos < start + 10'(`PCMB_WORD_BITS));
	endfunction

	function automatic logic is_last(input pcmb_pkg::pcmb_pos_t pos,
			input pcmb_pkg::pcmb_pos_t start);
		is_last = pos == start + 10'(`PCMB_WORD_BITS - 1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection

	logic [2:0] pins_s;
	logic       ck_q;
	logic       fs_q;

	pcmb_sync #(
		.WIDTH (3)
	) u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_link_bit_clock, i_link_frame_sync,
			i_link_receive_data}),
		.o_sync  (pins_s)
	);

	wire ck_s = pins_s[2];
	wire fs_s = pins_s[1];
	wire rx_s = pins_s[0];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ck_q <= 1'b0;
			fs_q <= 1'b0;
		end else begin
			ck_q <= ck_s;
			fs_q <= fs_s;
		end
	end

	wire clk_rise = ck_s & ~ck_q;
	wire clk_fall = ~ck_s & ck_q;
	wire fs_rise  = fs_s & ~fs_q;

	////////////////////////////////////////////////////////////////////////
	// sequencer state

	pcmb_pkg::pcmb_state_t state;
	pcmb_pkg::pcmb_state_t next_state;
	pcmb_pkg::pcmb_pos_t   bit_pos;
	logic                  half;
	logic                  fresh;
	logic                  check;
	wire                   run = state == pcmb_pkg::PCMB_ST_RUN;

	wire pcmb_pkg::pcmb_pos_t slot_start = i_b2_select ?
		10'(B2_START) : `PCMB_B1_START;

	wire pcmb_pkg::pcmb_pos_t pos_inc = (bit_pos == 10'h3ff) ?
		bit_pos : bit_pos + 10'h001;

	// one sync per frame restarts the count
	wire link_start = ~i_gci_mode & clk_fall & fs_s;
	wire link_rise  = ~i_gci_mode & run & clk_rise;
	wire link_fall  = ~i_gci_mode & run & clk_fall & ~link_start;

	// each frame pulse restarts the count
	wire gci_start = i_gci_mode & fs_rise;
	// sync rising with clock high counts as the first rise
	wire gci_rise  = i_gci_mode &
		((run & clk_rise & ~gci_start) | (gci_start & ck_s));
	wire gci_fall  = i_gci_mode & run & clk_fall & ~gci_start;

	wire                      g_fresh = gci_start | fresh;
	wire                      g_half  = ~g_fresh & ~half;
	wire pcmb_pkg::pcmb_pos_t g_pos   = gci_start ? 10'h000 :
		((fresh | ~half) ? bit_pos : pos_inc);

	// pulse must still be high at the first falling edge
	wire fs_abort = gci_fall & check & ~fs_s;

	wire any_start = link_start | gci_start;

	always_comb begin
		next_state = state;
		case (state)
			pcmb_pkg::PCMB_ST_IDLE: begin
				if (any_start) begin
					next_state = pcmb_pkg::PCMB_ST_RUN;
				end
			end
			pcmb_pkg::PCMB_ST_RUN: begin
				if (fs_abort) begin
					next_state = pcmb_pkg::PCMB_ST_IDLE;
				end
			end
			default: begin
				next_state = pcmb_pkg::PCMB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= pcmb_pkg::PCMB_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	wire pcmb_pkg::pcmb_pos_t next_pos = any_start ? 10'h000 :
		link_fall ? pos_inc :
		gci_rise  ? g_pos : bit_pos;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bit_pos <= 10'h000;
			half    <= 1'b0;
			fresh   <= 1'b0;
			check   <= 1'b0;
		end else begin
			bit_pos <= next_pos;
			half    <= gci_rise ? g_half : (any_start ? 1'b0 : half);
			fresh   <= gci_start ? ~ck_s : (gci_rise | link_start) ?
				1'b0 : fresh;
			check   <= gci_start ? 1'b1 : (gci_fall ? 1'b0 : check);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit path

	// link bits on rising edges inside the slot
	wire link_drive = link_rise & in_slot(bit_pos, slot_start);
	// gci bits on the first rise of each bit period
	wire gci_drive  = gci_rise & ~g_half & in_slot(g_pos, slot_start);
	wire drive      = link_drive | gci_drive;

	// release after the falling edge ending the word
	wire link_end = link_fall & is_last(bit_pos, slot_start);
	// release on the second falling edge of the last bit
	wire gci_end  = gci_fall & half & is_last(bit_pos, slot_start);
	wire word_end = run & (link_end | gci_end);
	wire release_oe = word_end | fs_abort;

	logic [7:0] tx_sh;
	// word is latched at frame start so the user may change it mid-frame
	wire [7:0] tx_src = any_start ? i_tx_word : tx_sh;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			tx_sh <= 8'h00;
		end else if (drive) begin
			tx_sh <= {tx_src[6:0], 1'b0};
		end else if (any_start) begin
			tx_sh <= i_tx_word;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_link_transmit_data <= 1'b0;
			o_link_transmit_oe   <= 1'b0;
			o_tx_taken           <= 1'b0;
		end else begin
			o_tx_taken <= any_start;
			if (drive) begin
				o_link_transmit_data <= tx_src[7];
			end
			if (drive) begin
				o_link_transmit_oe <= 1'b1;
			end else if (release_oe | (any_start & ~drive)) begin
				o_link_transmit_oe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive path

	wire link_cap = link_fall & in_slot(bit_pos, slot_start);
	// gci capture on the second rise, mid bit
	wire gci_cap  = gci_rise & g_half & in_slot(g_pos, slot_start);

	logic [7:0] rx_sh;
	logic       done_q;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rx_sh  <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= word_end;
			if (link_cap | gci_cap) begin
				rx_sh <= {rx_sh[6:0], rx_s};
			end
		end
	end

	// one cycle after word end so the link's last bit is in rx_sh
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rx_word  <= 8'h00;
			o_rx_valid <= 1'b0;
		end else begin
			o_rx_valid <= done_q;
			if (done_q) begin
				o_rx_word <= rx_sh;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame watchdog

	logic [WD_BITS-1:0] wd_cnt;
	wire                wd_over = wd_cnt >= WD_BITS'(LATE_CYCLES);

	// flags a far party that misses the frame rate
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wd_cnt      <= '0;
			o_sync_late <= 1'b0;
		end else begin
			if (any_start) begin
				wd_cnt <= '0;
			end else if (!wd_over) begin
				wd_cnt <= wd_cnt + WD_BITS'(1);
			end
			o_sync_late <= wd_over & ~any_start;
		end
	end

endmodule // pcmb_port

`default_nettype wire

// ---- rtl/pcmb_sync.sv ----
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to i_clock
// Notes:   only the second stage leaves this module
`default_nettype none

module pcmb_sync #(
	parameter int unsigned WIDTH = 3
) (
	// system
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule // pcmb_sync

`default_nettype wire
